/* File: core/gpio_pkg.sv */
// Constants, register map and carrier types for the dual GPIO port block.
// Assumes an APB slave with 32-bit data; each register is one aligned word.
package gpio_pkg;

    localparam logic [11:0] OFF_PIN_LEVEL_C = 12'h000;
    localparam logic [11:0] OFF_OUTPUT_LATCH_C = 12'h004;
    localparam logic [11:0] OFF_DIRECTION_C = 12'h008;
    localparam logic [11:0] OFF_PIN_LEVEL_D = 12'h00C;
    localparam logic [11:0] OFF_OUTPUT_LATCH_D = 12'h010;
    localparam logic [11:0] OFF_DIRECTION_D = 12'h014;
    localparam logic [11:0] OFF_SLAVE_PORT_CONTROL = 12'h018;
    localparam logic [11:0] OFF_MEMORY_BUS_CONTROL = 12'h01C;
    localparam logic [11:0] OFF_RESET_CONTROL = 12'h020;

    localparam logic [7:0] DIRECTION_RESET = 8'hFF;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] SLAVE_PORT_CONTROL_RESET = 8'h00;
    localparam logic [7:0] MEMORY_BUS_CONTROL_RESET = 8'h00;

    localparam int SYSTEM_BUS_DISABLE_BIT = 7;
    localparam int SLAVE_PORT_ENABLE_BIT = 4;
    localparam logic [7:0] SLAVE_PORT_CONTROL_MASK = 8'h10;
    localparam logic [7:0] MEMORY_BUS_CONTROL_MASK = 8'hB3;

    localparam int CAPCOMP2_PIN_BIT = 1;
    localparam int SERIAL_CLOCK_BIT = 3;
    localparam int SERIAL_DATA_IN_BIT = 4;
    localparam int SERIAL_DATA_OUT_BIT = 5;
    localparam int USART_TX_BIT = 6;
    localparam int USART_RX_BIT = 7;

    // Per-pin peripheral override request
    typedef struct packed {
        logic [7:0] force_out;
        logic [7:0] force_in;
        logic [7:0] data;
    } periph_override_s;

    // Pin pair
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_drive_s;

    typedef enum logic [2:0] {
        MODE_IO = 3'b001,
        MODE_SYSTEM_BUS = 3'b010,
        MODE_SLAVE_PORT = 3'b100
    } port_d_mode_e;

    typedef struct packed {
        logic [7:0] direction_c;
        logic [7:0] output_latch_c;
        logic [7:0] direction_d;
        logic [7:0] output_latch_d;
        logic [7:0] slave_port_control;
        logic [7:0] memory_bus_control;
        logic [7:0] sync_c_1;
        logic [7:0] sync_c_2;
        logic [7:0] sync_d_1;
        logic [7:0] sync_d_2;
        port_d_mode_e mode_d;
        pin_drive_s pins_c;
        pin_drive_s pins_d;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_s;

endpackage

/* File: core/dual_gpio_port.sv */
// Two 8-bit GPIO ports with peripheral override and system-bus / slave-port sharing.
// Assumes APB master on pclk; pins and peripheral signals synchronous to pclk.
//
// Implementation choices: register access over APB and the address map.
module dual_gpio_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pin_c_in,
    output logic [7:0] pin_c_out,
    output logic [7:0] pin_c_oe,
    input wire logic [7:0] pin_d_in,
    output logic [7:0] pin_d_out,
    output logic [7:0] pin_d_oe,
    input wire logic capcomp2_pin_select,
    input wire logic capcomp_unit_two_oe,
    input wire logic capcomp_unit_two_out,
    input wire logic capcomp_unit_one_oe,
    input wire logic capcomp_unit_one_out,
    input wire logic timer_osc_enable,
    input wire logic serial_enable,
    input wire logic serial_clock_master,
    input wire logic serial_clock_out,
    input wire logic serial_data_oe,
    input wire logic serial_data_out,
    input wire logic usart_enable,
    input wire logic usart_tx_oe,
    input wire logic usart_tx_out,
    input wire logic usart_rx_oe,
    input wire logic usart_rx_out,
    input wire logic system_bus_request,
    input wire logic system_bus_oe,
    input wire logic [7:0] system_bus_data_out,
    input wire logic slave_port_drive,
    input wire logic [7:0] slave_port_data_out,
    output logic [7:0] port_c_level,
    output logic [7:0] port_d_level,
    output logic slave_port_active,
    output logic system_bus_active
);

    ////////////////////////////////////////////////////////////////////////////
    // Peripheral routing on port C

    gpio_pkg::periph_override_s ovr_c;
    logic [7:0] ovr_c_force_out;
    logic [7:0] ovr_c_force_in;
    logic [7:0] ovr_c_data;

    // Fixed bit positions, so a loop would hide the mapping
    always_comb begin
        ovr_c_force_out = 8'h00;
        ovr_c_force_in = 8'h00;
        ovr_c_data = 8'h00;
        if (timer_osc_enable) begin
            ovr_c_force_in[0] = 1'b1;
            ovr_c_force_in[gpio_pkg::CAPCOMP2_PIN_BIT] = 1'b1;
        end
        if (capcomp2_pin_select && capcomp_unit_two_oe) begin
            ovr_c_force_out[gpio_pkg::CAPCOMP2_PIN_BIT] = 1'b1;
            ovr_c_data[gpio_pkg::CAPCOMP2_PIN_BIT] = capcomp_unit_two_out;
        end
        if (capcomp_unit_one_oe) begin
            ovr_c_force_out[2] = 1'b1;
            ovr_c_data[2] = capcomp_unit_one_out;
        end
        if (serial_enable) begin
            if (serial_clock_master) begin
                ovr_c_force_out[gpio_pkg::SERIAL_CLOCK_BIT] = 1'b1;
                ovr_c_data[gpio_pkg::SERIAL_CLOCK_BIT] = serial_clock_out;
            end else begin
                ovr_c_force_in[gpio_pkg::SERIAL_CLOCK_BIT] = 1'b1;
            end
            ovr_c_force_in[gpio_pkg::SERIAL_DATA_IN_BIT] = ~serial_data_oe;
            ovr_c_force_out[gpio_pkg::SERIAL_DATA_IN_BIT] = serial_data_oe;
            ovr_c_data[gpio_pkg::SERIAL_DATA_IN_BIT] = serial_data_out;
            ovr_c_force_out[gpio_pkg::SERIAL_DATA_OUT_BIT] = 1'b1;
            ovr_c_data[gpio_pkg::SERIAL_DATA_OUT_BIT] = serial_data_out;
        end
        if (usart_enable) begin
            ovr_c_force_out[gpio_pkg::USART_TX_BIT] = usart_tx_oe;
            ovr_c_force_in[gpio_pkg::USART_TX_BIT] = ~usart_tx_oe;
            ovr_c_data[gpio_pkg::USART_TX_BIT] = usart_tx_out;
            ovr_c_force_out[gpio_pkg::USART_RX_BIT] = usart_rx_oe;
            ovr_c_force_in[gpio_pkg::USART_RX_BIT] = ~usart_rx_oe;
            ovr_c_data[gpio_pkg::USART_RX_BIT] = usart_rx_out;
        end
        ovr_c.force_out = ovr_c_force_out;
        ovr_c.force_in = ovr_c_force_in;
        ovr_c.data = ovr_c_data;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State

    gpio_pkg::state_s state_reg;
    gpio_pkg::state_s state_next;

    logic setup_phase;
    logic access_phase;
    logic [31:0] rd_word;
    logic mapped;
    logic [7:0] wbyte;
    logic bus_enabled;

    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign wbyte = pwdata[7:0];
    // System bus owns port D on request unless disabled
    assign bus_enabled = !state_reg.memory_bus_control[gpio_pkg::SYSTEM_BUS_DISABLE_BIT];

    // Read mux
    always_comb begin
        rd_word = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            gpio_pkg::OFF_PIN_LEVEL_C: rd_word[7:0] = state_reg.sync_c_2;
            gpio_pkg::OFF_OUTPUT_LATCH_C: rd_word[7:0] = state_reg.output_latch_c;
            gpio_pkg::OFF_DIRECTION_C: rd_word[7:0] = state_reg.direction_c;
            gpio_pkg::OFF_PIN_LEVEL_D: rd_word[7:0] = state_reg.sync_d_2;
            gpio_pkg::OFF_OUTPUT_LATCH_D: rd_word[7:0] = state_reg.output_latch_d;
            gpio_pkg::OFF_DIRECTION_D: rd_word[7:0] = state_reg.direction_d;
            gpio_pkg::OFF_SLAVE_PORT_CONTROL: rd_word[7:0] = state_reg.slave_port_control;
            gpio_pkg::OFF_MEMORY_BUS_CONTROL: rd_word[7:0] = state_reg.memory_bus_control;
            gpio_pkg::OFF_RESET_CONTROL: rd_word = 32'h0000_0000;
            default: mapped = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        state_next = state_reg;
        // Two flops per port; only the second one is read elsewhere
        state_next.sync_c_1 = pin_c_in;
        state_next.sync_c_2 = state_reg.sync_c_1;
        state_next.sync_d_1 = pin_d_in;
        state_next.sync_d_2 = state_reg.sync_d_1;

        // No wait state: answer in the cycle after setup
        state_next.pready = setup_phase;
        state_next.pslverr = setup_phase && !mapped;
        state_next.prdata = (setup_phase && !pwrite) ? rd_word : 32'h0000_0000;

        if (access_phase && pready && pwrite && mapped && pstrb[0]) begin
            case (paddr)
                gpio_pkg::OFF_PIN_LEVEL_C: state_next.output_latch_c = wbyte;
                gpio_pkg::OFF_OUTPUT_LATCH_C: state_next.output_latch_c = wbyte;
                gpio_pkg::OFF_DIRECTION_C: state_next.direction_c = wbyte;
                gpio_pkg::OFF_PIN_LEVEL_D: state_next.output_latch_d = wbyte;
                gpio_pkg::OFF_OUTPUT_LATCH_D: state_next.output_latch_d = wbyte;
                gpio_pkg::OFF_DIRECTION_D: state_next.direction_d = wbyte;
                gpio_pkg::OFF_SLAVE_PORT_CONTROL:
                    state_next.slave_port_control = wbyte & gpio_pkg::SLAVE_PORT_CONTROL_MASK;
                gpio_pkg::OFF_MEMORY_BUS_CONTROL:
                    state_next.memory_bus_control = wbyte & gpio_pkg::MEMORY_BUS_CONTROL_MASK;
                gpio_pkg::OFF_RESET_CONTROL: begin
                    // Soft reset: directions and controls, latches unchanged
                    if (wbyte[0]) begin
                        state_next.direction_c = gpio_pkg::DIRECTION_RESET;
                        state_next.direction_d = gpio_pkg::DIRECTION_RESET;
                        state_next.slave_port_control = gpio_pkg::SLAVE_PORT_CONTROL_RESET;
                        state_next.memory_bus_control = gpio_pkg::MEMORY_BUS_CONTROL_RESET;
                    end
                end
                default: state_next.prdata = state_reg.prdata;
            endcase
        end

        // Port D mode: system bus wins over slave port
        if (bus_enabled && system_bus_request) begin
            state_next.mode_d = gpio_pkg::MODE_SYSTEM_BUS;
        end else if (state_reg.slave_port_control[gpio_pkg::SLAVE_PORT_ENABLE_BIT]) begin
            state_next.mode_d = gpio_pkg::MODE_SLAVE_PORT;
        end else begin
            state_next.mode_d = gpio_pkg::MODE_IO;
        end

        // Port C pins; override stays out of direction_c
        for (int i = 0; i < 8; i++) begin
            if (ovr_c.force_out[i]) begin
                state_next.pins_c.oe[i] = 1'b1;
                state_next.pins_c.out[i] = ovr_c.data[i];
            end else if (ovr_c.force_in[i]) begin
                state_next.pins_c.oe[i] = 1'b0;
                state_next.pins_c.out[i] = 1'b0;
            end else begin
                state_next.pins_c.oe[i] = !state_next.direction_c[i];
                state_next.pins_c.out[i] = state_next.output_latch_c[i];
            end
        end

        // Port D pins, bit n maps straight to bus bit n
        case (state_next.mode_d)
            gpio_pkg::MODE_SYSTEM_BUS: begin
                state_next.pins_d.oe = {8{system_bus_oe}};
                state_next.pins_d.out = system_bus_data_out;
            end
            gpio_pkg::MODE_SLAVE_PORT: begin
                state_next.pins_d.oe = {8{slave_port_drive}};
                state_next.pins_d.out = slave_port_data_out;
            end
            gpio_pkg::MODE_IO: begin
                state_next.pins_d.oe = ~state_next.direction_d;
                state_next.pins_d.out = state_next.output_latch_d;
            end
            default: begin
                state_next.pins_d.oe = 8'h00;
                state_next.pins_d.out = 8'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers; latches reset to a fixed value standing in for unknown

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.direction_c <= gpio_pkg::DIRECTION_RESET;
            state_reg.direction_d <= gpio_pkg::DIRECTION_RESET;
            state_reg.output_latch_c <= gpio_pkg::LATCH_RESET;
            state_reg.output_latch_d <= gpio_pkg::LATCH_RESET;
            state_reg.slave_port_control <= gpio_pkg::SLAVE_PORT_CONTROL_RESET;
            state_reg.memory_bus_control <= gpio_pkg::MEMORY_BUS_CONTROL_RESET;
            state_reg.sync_c_1 <= 8'h00;
            state_reg.sync_c_2 <= 8'h00;
            state_reg.sync_d_1 <= 8'h00;
            state_reg.sync_d_2 <= 8'h00;
            state_reg.mode_d <= gpio_pkg::MODE_IO;
            state_reg.pins_c <= '0;
            state_reg.pins_d <= '0;
            state_reg.prdata <= 32'h0000_0000;
            state_reg.pready <= 1'b0;
            state_reg.pslverr <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign pin_c_out = state_reg.pins_c.out;
    assign pin_c_oe = state_reg.pins_c.oe;
    assign pin_d_out = state_reg.pins_d.out;
    assign pin_d_oe = state_reg.pins_d.oe;
    assign port_c_level = state_reg.sync_c_2;
    assign port_d_level = state_reg.sync_d_2;
    // One-hot mode, so each flag is a single flop bit
    assign slave_port_active = state_reg.mode_d[2];
    assign system_bus_active = state_reg.mode_d[1];

endmodule

/* File: dv/pin_world.sv */
// Outside world seen by one 8-bit port: pins the block releases follow ext.
// Assumes oe high means the block drives that pin.
module pin_world (
    input wire logic [7:0] oe,
    input wire logic [7:0] out,
    input wire logic [7:0] ext,
    output logic [7:0] level
);
    timeunit 1ns;
    timeprecision 1ns;
    // Released pins show the outside driver, never the last driven value
    assign level = (oe & out) | (~oe & ext);
endmodule

/* File: dv/dual_gpio_port_assertions.sv */
// Concurrent checks on the dual GPIO port boundary.
// Assumes one pclk domain and presetn asynchronous, active low.
module dual_gpio_port_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] pin_c_in,
    input wire logic [7:0] pin_c_out,
    input wire logic [7:0] pin_c_oe,
    input wire logic [7:0] pin_d_out,
    input wire logic [7:0] pin_d_oe,
    input wire logic timer_osc_enable,
    input wire logic serial_enable,
    input wire logic serial_data_out,
    input wire logic usart_enable,
    input wire logic usart_tx_oe,
    input wire logic system_bus_oe,
    input wire logic [7:0] system_bus_data_out,
    input wire logic [7:0] port_c_level,
    input wire logic system_bus_active
);
    logic [1:0] up_cnt;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    // Synchronizer history is meaningless until three edges after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    a_unmapped_error: assert property (psel && !penable && paddr > 12'h020
        && paddr[1:0] == 2'h0 |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_usart_tx_dir: assert property (usart_enable |=> pin_c_oe[6] == $past(usart_tx_oe))
        else $error("usart transmit pin direction wrong");
    a_serial_out_pin: assert property (serial_enable |=> pin_c_oe[5]
        && pin_c_out[5] == $past(serial_data_out))
        else $error("serial data out pin wrong");
    a_timer_forces_in: assert property (timer_osc_enable |=> !pin_c_oe[0])
        else $error("timer oscillator pin driven");
    a_bus_drive_d: assert property (system_bus_active && $past(system_bus_active)
        |-> pin_d_oe == {8{$past(system_bus_oe)}}
        && (!pin_d_oe[0] || pin_d_out == $past(system_bus_data_out)))
        else $error("bus mode drive on port d wrong");
    a_level_two_sync: assert property (up_cnt == 2'h3 |-> port_c_level == $past(pin_c_in, 2))
        else $error("port c level not two edges behind pins");
endmodule

bind dual_gpio_port dual_gpio_port_checker u_chk (.*);

/* File: dv/testbench.sv */
// Self-checking bench for the dual GPIO port over APB.
// Assumes the slave answers with pready within a bounded wait; pins registered one edge late.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, slave_port_active, system_bus_active;
    logic [7:0] pin_c_in, pin_c_out, pin_c_oe, pin_d_in, pin_d_out, pin_d_oe;
    logic [7:0] port_c_level, port_d_level, ext_c = 8'h96, ext_d = 8'h69;
    logic capcomp2_pin_select = 1'b1, capcomp_unit_two_oe = 1'b0, capcomp_unit_two_out = 1'b0;
    logic capcomp_unit_one_oe = 1'b0, capcomp_unit_one_out = 1'b0, timer_osc_enable = 1'b0;
    logic serial_enable = 1'b0, serial_clock_master = 1'b0, serial_clock_out = 1'b0;
    logic serial_data_oe = 1'b0, serial_data_out = 1'b0, usart_enable = 1'b0;
    logic usart_tx_oe = 1'b0, usart_tx_out = 1'b0, usart_rx_oe = 1'b0, usart_rx_out = 1'b0;
    logic system_bus_request = 1'b0, system_bus_oe = 1'b0, slave_port_drive = 1'b0;
    logic [7:0] system_bus_data_out = 8'h00, slave_port_data_out = 8'h00;
    logic [31:0] r;
    logic e;
    int errors = 0, n_checks = 0;
    ////////////////////////////////////////////////////////////////////////////////
    dual_gpio_port u_dut (.*);
    pin_world u_world_c (.oe(pin_c_oe), .out(pin_c_out), .ext(ext_c), .level(pin_c_in));
    pin_world u_world_d (.oe(pin_d_oe), .out(pin_d_out), .ext(ext_d), .level(pin_d_in));
    initial begin
        forever #5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            errors++;
        end
    endtask
    // Pready, data and error are all taken at the rising edge that sees pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            close_out();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task automatic rd(input string nm, input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, {24'h0, exp}, r);
    endtask
    // Pins land one edge late and pass a two-stage synchronizer
    task automatic settle;
        repeat (4) @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd("direction_c", gpio_pkg::OFF_DIRECTION_C, 8'hFF);
        rd("direction_d", gpio_pkg::OFF_DIRECTION_D, 8'hFF);
        rd("memory_bus_control", gpio_pkg::OFF_MEMORY_BUS_CONTROL, 8'h00);
        wr(gpio_pkg::OFF_PIN_LEVEL_C, 8'hA5);
        rd("output_latch_c", gpio_pkg::OFF_OUTPUT_LATCH_C, 8'hA5);
        wr(gpio_pkg::OFF_OUTPUT_LATCH_C, 8'h3C);
        wr(gpio_pkg::OFF_DIRECTION_C, 8'hF0);
        settle();
        chk("pin_c_oe", 32'h0F, {24'h0, pin_c_oe});
        chk("pin_c_out", 32'hC, {28'h0, pin_c_out[3:0]});
        rd("pin_level_c", gpio_pkg::OFF_PIN_LEVEL_C, 8'h9C);
        rd("output_latch_c", gpio_pkg::OFF_OUTPUT_LATCH_C, 8'h3C);
        // Every override source except capcomp unit one at once, pins 0, 1 and 3 to 7
        usart_enable <= 1'b1;
        usart_tx_oe <= 1'b1;
        usart_tx_out <= 1'b1;
        serial_enable <= 1'b1;
        serial_data_out <= 1'b1;
        timer_osc_enable <= 1'b1;
        capcomp_unit_two_oe <= 1'b1;
        capcomp_unit_two_out <= 1'b1;
        settle();
        chk("pin_c_oe", 32'h66, {24'h0, pin_c_oe});
        chk("pin_c_out", 32'h3, {30'h0, pin_c_out[6:5]});
        chk("pin_c_out", 32'h1, {31'h0, pin_c_out[1]});
        rd("direction_c", gpio_pkg::OFF_DIRECTION_C, 8'hF0);
        usart_enable <= 1'b0;
        serial_enable <= 1'b0;
        timer_osc_enable <= 1'b0;
        wr(gpio_pkg::OFF_MEMORY_BUS_CONTROL, 8'hFF);
        rd("memory_bus_control", gpio_pkg::OFF_MEMORY_BUS_CONTROL, 8'hB3);
        wr(gpio_pkg::OFF_DIRECTION_D, 8'h00);
        wr(gpio_pkg::OFF_OUTPUT_LATCH_D, 8'h5A);
        system_bus_request <= 1'b1;
        system_bus_oe <= 1'b1;
        system_bus_data_out <= 8'hC3;
        settle();
        chk("pin_d_out", 32'h5A, {24'h0, pin_d_out});
        chk("pin_d_oe", 32'hFF, {24'h0, pin_d_oe});
        chk("port_d_level", 32'h5A, {24'h0, port_d_level});
        rd("pin_level_d", gpio_pkg::OFF_PIN_LEVEL_D, 8'h5A);
        wr(gpio_pkg::OFF_MEMORY_BUS_CONTROL, 8'h00);
        settle();
        chk("system_bus_active", 32'h1, {31'h0, system_bus_active});
        chk("pin_d_out", 32'hC3, {24'h0, pin_d_out});
        chk("pin_d_oe", 32'hFF, {24'h0, pin_d_oe});
        system_bus_request <= 1'b0;
        wr(gpio_pkg::OFF_SLAVE_PORT_CONTROL, 8'hFF);
        rd("slave_port_control", gpio_pkg::OFF_SLAVE_PORT_CONTROL, 8'h10);
        slave_port_drive <= 1'b1;
        slave_port_data_out <= 8'h81;
        settle();
        chk("slave_port_active", 32'h1, {31'h0, slave_port_active});
        chk("pin_d_out", 32'h81, {24'h0, pin_d_out});
        wr(gpio_pkg::OFF_RESET_CONTROL, 8'h01);
        rd("direction_d", gpio_pkg::OFF_DIRECTION_D, 8'hFF);
        rd("output_latch_d", gpio_pkg::OFF_OUTPUT_LATCH_D, 8'h5A);
        rd("output_latch_c", gpio_pkg::OFF_OUTPUT_LATCH_C, 8'h3C);
        apb(1'b0, 12'h024, 32'h0);
        chk("pslverr", 32'h1, {31'h0, e});
        close_out();
    end
endmodule
